// File: bench/cmp_core_model.sv
// Purpose: behavioural analog comparator core with its input pins
// Assumes: input voltages given as unsigned codes
// Notes:   output left high while unpowered, the block must hide it
`timescale 1ns/100ps
module cmp_core_model #(
  parameter [7:0] BANDGAP_LEVEL = 8'h80
) (
  // levels
  input wire [7:0]  pos_level,
  input wire [7:0]  neg_level,
  input wire [63:0] mux_levels,
  // controls and result
  input wire        power_off,
  input wire        bandgap_sel,
  input wire        use_mux,
  input wire [2:0]  mux_pin,
  output wire       result
);
  wire [7:0] p = bandgap_sel ? BANDGAP_LEVEL : pos_level;
  wire [7:0] n = use_mux ? mux_levels[mux_pin*8 +: 8] : neg_level;
  assign result = power_off ? 1'b1 : (p > n);
endmodule // cmp_core_model

// File: bench/cmp_ctrl_checker.sv
// Purpose: port level checks of the comparator control block
// Assumes: one clock, synchronous active low reset
// Notes:   attached by bind
`timescale 1ns/100ps
module cmp_ctrl_checker (
  // clock, reset and bus
  input wire        clk,
  input wire        rst_b,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire        pslverr,
  // core, pins and interrupts
  input wire        cmp_raw,
  input wire        cmp_power_off,
  input wire        bandgap_select,
  input wire [2:0]  neg_mux_pin,
  input wire        pin0_buf_enable,
  input wire        pin1_buf_enable,
  input wire        cpu_global_irq_en,
  input wire        irq_vector_ack,
  input wire        cmp_irq,
  input wire        irq,
  input wire        capture_out
);
  wire [9:0] idx = paddr[11:2];
  wire       wr  = psel && penable && pwrite && pstrb[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_bus_ready: assert property (psel && penable |-> pready)
    else $error("bus access not ready");
  chk_unmapped_err: assert property (psel && penable |->
    pslverr == !(idx == 3 || (idx >= 8 && idx <= 13))) else $error("slave error wrong");
  chk_buf_update: assert property (wr && idx == 9 |=>
    {pin1_buf_enable, pin0_buf_enable} == ~$past(pwdata[1:0])) else $error("buffer enable");
  chk_ctrl_update: assert property (wr && idx == 8 |=>
    cmp_power_off == $past(pwdata[7]) && bandgap_select == $past(pwdata[6]))
    else $error("power or bandgap control");
  chk_mux_pin: assert property (wr && idx == 11 |=> neg_mux_pin == $past(pwdata[2:0]))
    else $error("mux pin select");
  chk_capture_cause: assert property ($rose(capture_out) |-> $past(cmp_raw, 3))
    else $error("capture rose without result");
  chk_irq_global: assert property (cmp_irq |-> cpu_global_irq_en)
    else $error("request without global enable");
  chk_flag_clear: assert property ((irq_vector_ack || wr && idx == 8 && pwdata[4]) &&
    $stable(cmp_raw) && $past(cmp_raw, 2) == cmp_raw && $past(cmp_raw, 3) == cmp_raw
    |=> !cmp_irq && !irq) else $error("flag not cleared");
endmodule // cmp_ctrl_checker

bind cmp_ctrl cmp_ctrl_checker chk_i (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .cmp_power_off(cmp_power_off),
  .bandgap_select(bandgap_select), .neg_mux_pin(neg_mux_pin),
  .pin0_buf_enable(pin0_buf_enable), .pin1_buf_enable(pin1_buf_enable),
  .cpu_global_irq_en(cpu_global_irq_en), .irq_vector_ack(irq_vector_ack),
  .cmp_irq(cmp_irq), .irq(irq), .capture_out(capture_out));

// File: bench/cmp_ctrl_tb_top.sv
// Purpose: self-checking bench of the comparator control block
// Assumes: zero wait state bus
// Notes:   reads are checked by a monitor against a queue of expected data
`timescale 1ns/100ps
module cmp_ctrl_tb_top;
  reg         clk, rst_b, psel, penable, pwrite, cpu_global_irq_en, irq_vector_ack;
  reg         cmp_pos_pin_in, cmp_neg_pin_in;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  reg  [3:0]  pstrb;
  reg  [7:0]  pos_v, neg_v, rnd, e;
  reg  [63:0] mux_v;
  wire        pready, pslverr, cmp_raw, cmp_power_off, bandgap_select, neg_use_mux;
  wire        pin0_buf_enable, pin1_buf_enable, cmp_irq, irq, capture_out;
  wire [2:0]  neg_mux_pin;
  wire [31:0] prdata;
  integer     err_count, total_checks, i;
  reg  [7:0]  expq[$];
  cmp_ctrl dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .cmp_power_off(cmp_power_off),
    .bandgap_select(bandgap_select), .neg_use_mux(neg_use_mux), .neg_mux_pin(neg_mux_pin),
    .cmp_pos_pin_in(cmp_pos_pin_in), .cmp_neg_pin_in(cmp_neg_pin_in),
    .pin0_buf_enable(pin0_buf_enable), .pin1_buf_enable(pin1_buf_enable),
    .cpu_global_irq_en(cpu_global_irq_en), .irq_vector_ack(irq_vector_ack),
    .cmp_irq(cmp_irq), .irq(irq), .capture_out(capture_out));
  cmp_core_model core (.pos_level(pos_v), .neg_level(neg_v), .mux_levels(mux_v),
    .power_off(cmp_power_off), .bandgap_sel(bandgap_select), .use_mux(neg_use_mux),
    .mux_pin(neg_mux_pin), .result(cmp_raw));
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input [7:0] ix, input w, input [7:0] d, input [7:0] x);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, ix, 2'h0};
      pwdata <= {24'h00_0000, d};
      pstrb <= 4'hf;
      if (!w) expq.push_back(x);
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task w4;
    repeat (4) @(posedge clk);
  endtask
  task summarize;
    begin
      if (err_count == 0 && total_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready) begin
      e = expq.pop_front();
      chk(prdata, {24'h00_0000, e}, "prdata");
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count = err_count + 1;
    summarize;
  end
  initial begin
    {psel, penable, pwrite, cpu_global_irq_en, irq_vector_ack} = 5'h00;
    {cmp_pos_pin_in, cmp_neg_pin_in, rst_b, paddr, pwdata, pstrb} = 51'h0;
    {pos_v, neg_v, mux_v, rnd} = {8'h10, 8'h80, 64'h0, 8'h45};
    {err_count, total_checks} = 64'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({pin1_buf_enable, pin0_buf_enable, capture_out}, 3'h6, "reset pins");
    apb(8'h03, 0, 8'h00, 8'h00);
    apb(8'h20, 0, 8'h00, 8'h00);
    apb(8'h08, 1, 8'h01, 8'h00);
    apb(8'h03, 1, 8'h40, 8'h00);
    {pos_v, mux_v[63:56]} <= {8'h80, 8'hff};
    for (i = 0; i < 8; i = i + 1) begin
      rnd = lfsr(rnd);
      mux_v[i*8 +: 8] <= rnd;
      apb(8'h0b, 1, i[7:0], 8'h00);
      w4;
      apb(8'h08, 0, 8'h00, {2'h0, rnd < 8'h80, 5'h01});
    end
    apb(8'h0a, 1, 8'h80, 8'h00);
    // converter pin 7 would give low, so a high result proves the dedicated pin
    {pos_v, mux_v[63:56]} <= {8'hc0, 8'hff};
    w4;
    apb(8'h08, 0, 8'h00, 8'h21);
    apb(8'h0a, 1, 8'h00, 8'h00);
    w4;
    apb(8'h08, 0, 8'h00, 8'h01);
    apb(8'h03, 1, 8'h00, 8'h00);
    apb(8'h08, 1, 8'h41, 8'h00);
    w4;
    apb(8'h08, 0, 8'h00, 8'h41);
    for (i = 0; i < 4; i = i + 1) begin
      pos_v <= 8'h10;
      w4;
      // mode changed with interrupt enable clear
      apb(8'h08, 1, 8'h10 | i[7:0], 8'h00);
      pos_v <= 8'hc0;
      w4;
      apb(8'h08, 0, 8'h00, {3'h1, i == 0 || i == 3, 2'h0, i[1:0]});
      apb(8'h08, 1, i[7:0], 8'h00);
      pos_v <= 8'h10;
      w4;
      apb(8'h08, 0, 8'h00, {3'h0, i != 1, 2'h0, i[1:0]});
    end
    apb(8'h0d, 1, 8'h10, 8'h00);
    apb(8'h08, 1, 8'h1b, 8'h00);
    cpu_global_irq_en <= 1'b1;
    pos_v <= 8'hc0;
    w4;
    @(negedge clk);
    chk({cmp_irq, irq}, 2'h3, "irq");
    @(posedge clk) cpu_global_irq_en <= 1'b0;
    apb(8'h0d, 1, 8'h00, 8'h00);
    chk({cmp_irq, irq}, 2'h0, "irq");
    apb(8'h0d, 1, 8'h10, 8'h00);
    irq_vector_ack <= 1'b1;
    @(posedge clk) irq_vector_ack <= 1'b0;
    @(negedge clk);
    chk({cmp_irq, irq}, 2'h0, "irq");
    @(posedge clk);
    // enable cleared before the mode changes
    apb(8'h08, 1, 8'h03, 8'h00);
    apb(8'h08, 1, 8'h05, 8'h00);
    @(negedge clk);
    chk(capture_out, 1'b1, "capture_out");
    @(posedge clk);
    apb(8'h08, 1, 8'h81, 8'h00);
    w4;
    apb(8'h08, 0, 8'h00, 8'h81);
    for (i = 0; i < 4; i = i + 1) begin
      rnd = lfsr(rnd);
      {cmp_neg_pin_in, cmp_pos_pin_in} <= rnd[1:0];
      apb(8'h09, 1, i[7:0], 8'h00);
      apb(8'h0c, 0, 8'h00, {6'h00, rnd[1:0] & ~i[1:0]});
      chk({pin1_buf_enable, pin0_buf_enable}, 2'h3 ^ i[1:0], "buf_enable");
    end
    summarize;
  end
endmodule // cmp_ctrl_tb_top

// File: logic/cmp_ctrl.v
// Purpose: control and status logic around an on-chip analog comparator, APB register access
// Assumes: analog core reports its raw result asynchronously; all other inputs synchronous
// Notes:   selects inputs, synchronises result, raises events and routes to timer capture
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`include "cmp_ctrl_regs.vh"

// Behaviour
// - result is high while positive input voltage exceeds negative input voltage
// - mux enabled and converter off: select code 0..7 picks converter pin
// - mux disabled or converter on: dedicated negative pin is used
// - bandgap select bit 6 replaces positive pin with internal reference
// - power-off bit 7 switches comparator off at once, any state
// - result is synchronised before appearing as read-only bit 5
// - flag bit 4 sets when synchronised change matches selected mode
// - flag clears when the processor takes the comparator vector
// - writing one clears the flag; writing zero leaves it
// - cmp_irq requested only with flag, enable bit 3 and global enable; irq only with flag and mask bit 4
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising
// - capture bit 2 routes result to timer capture front end
// - input-off bits 1/0 disable pin buffers, pin reads return zero
// - converter enable blocks comparator input multiplexing
module cmp_ctrl (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // analog core
  input  wire        cmp_raw,
  output wire        cmp_power_off,
  output wire        bandgap_select,
  output wire        neg_use_mux,
  output wire [2:0]  neg_mux_pin,
  // pins
  input  wire        cmp_pos_pin_in,
  input  wire        cmp_neg_pin_in,
  output wire        pin0_buf_enable,
  output wire        pin1_buf_enable,
  // processor and timer
  input  wire        cpu_global_irq_en,
  input  wire        irq_vector_ack,
  output wire        cmp_irq,
  output wire        irq,
  output reg         capture_out
);

  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [7:0] conv_ctrl_status_b_reg;
  reg  [7:0] cmp_ctrl_status_reg;
  reg  [7:0] digital_input_disable_0_reg;
  reg  [7:0] conv_ctrl_a_reg;
  reg  [7:0] conv_mux_reg;
  reg  [7:0] cmp_irq_mask_reg;
  reg        sync1_reg;
  reg        sync2_reg;
  reg        flag_reg;
  reg        flag_next;
  reg  [1:0] pin_in_reg;
  wire       cmp_event;
  wire       converter_enable;
  wire [4:0] conv_mux_select;
  wire [1:0] irq_mode;
  wire       wr_en;
  wire       rd_en;
  wire [9:0] idx;
  wire       mapped;
  wire       wr_flag_clr;
  reg [31:0] rdata_next;
  wire       wr_byte0;
  wire       rd_setup;
  wire       cmp_gated;
  wire       flag_clear;
  wire       mux_code_valid;
  wire       sel_conv_b;
  wire       sel_cmp_ctrl;
  wire       sel_dig_off;
  wire       sel_conv_a;
  wire       sel_conv_mux;
  wire       sel_pin_in;
  wire       sel_irq_mask;

  assign idx      = paddr[11:2];
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & ~pwrite;
  assign pready   = 1'b1;
  assign wr_byte0 = wr_en & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;

  // ****************************************************************
  // register select
  // ****************************************************************
  assign sel_conv_b   = (idx == {2'b00, `IDX_CONV_CTRL_STATUS_B});
  assign sel_cmp_ctrl = (idx == {2'b00, `IDX_CMP_CTRL_STATUS});
  assign sel_dig_off  = (idx == {2'b00, `IDX_DIG_INPUT_DISABLE_0});
  assign sel_conv_a   = (idx == {2'b00, `IDX_CONV_CTRL_A});
  assign sel_conv_mux = (idx == {2'b00, `IDX_CONV_MUX});
  assign sel_pin_in   = (idx == {2'b00, `IDX_PIN_INPUT});
  assign sel_irq_mask = (idx == {2'b00, `IDX_CMP_IRQ_MASK});
  assign mapped       = sel_conv_b | sel_cmp_ctrl | sel_dig_off | sel_conv_a |
                        sel_conv_mux | sel_pin_in | sel_irq_mask;
  // unmapped index answers with an error, write dropped, read zero
  assign pslverr      = psel & penable & ~mapped;

  assign converter_enable = conv_ctrl_a_reg[`BIT_CONVERTER_ENABLE];
  assign conv_mux_select  = conv_mux_reg[4:0];
  assign irq_mode         = {cmp_ctrl_status_reg[`BIT_IRQ_MODE_HI],
                             cmp_ctrl_status_reg[`BIT_IRQ_MODE_LO]};

  // ****************************************************************
  // analog input selection
  // ****************************************************************
  // power off immediate
  assign cmp_power_off  = cmp_ctrl_status_reg[`BIT_CMP_POWER_OFF];
  assign bandgap_select = cmp_ctrl_status_reg[`BIT_BANDGAP_SELECT];
  // only codes 00000..00111 name a converter pin, others keep the dedicated pin
  assign mux_code_valid = (conv_mux_select[4:3] == 2'b00);
  assign neg_use_mux    = conv_ctrl_status_b_reg[`BIT_NEG_MUX_ENABLE] & ~converter_enable &
                          mux_code_valid;
  assign neg_mux_pin    = conv_mux_select[2:0];
  assign pin0_buf_enable = ~digital_input_disable_0_reg[`BIT_PIN0_INPUT_OFF];
  assign pin1_buf_enable = ~digital_input_disable_0_reg[`BIT_PIN1_INPUT_OFF];

  // ****************************************************************
  // result synchroniser
  // ****************************************************************
  // unpowered core reads low
  assign cmp_gated = cmp_raw & ~cmp_power_off;

  // core result, forced low when off
  // two-stage sync
  // only the second stage is read, the first may still be settling
  always @(posedge clk) begin
    if (!rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= cmp_gated;
      sync2_reg <= sync1_reg;
    end
  end

  edge_event u_edge_event (
    .clk         (clk),
    .rst_b       (rst_b),
    .level       (sync2_reg),
    .mode        (irq_mode),
    .event_pulse (cmp_event)
  );

  // ****************************************************************
  // interrupt flag
  // ****************************************************************
  assign wr_flag_clr = wr_byte0 & sel_cmp_ctrl & pwdata[`BIT_CMP_IRQ_FLAG];
  assign flag_clear  = irq_vector_ack | wr_flag_clr;

  always @* begin
    flag_next = flag_reg;
    if (flag_clear) begin
      flag_next = 1'b0;
    end
    if (cmp_event) begin
      flag_next = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign cmp_irq = flag_reg & cmp_ctrl_status_reg[`BIT_CMP_IRQ_ENABLE] & cpu_global_irq_en;
  // second request line, gated by the local mask instead of the enable bit
  assign irq     = flag_reg & cmp_irq_mask_reg[`BIT_CMP_IRQ_FLAG];

  // ****************************************************************
  // capture routing
  // ****************************************************************
  // one register more so the timer front end sees a clean level
  always @(posedge clk) begin
    if (!rst_b) begin
      capture_out <= 1'b0;
    end else begin
      capture_out <= sync2_reg & cmp_ctrl_status_reg[`BIT_CAPTURE_ROUTE_EN];
    end
  end

  // ****************************************************************
  // pin inputs
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      pin_in_reg <= 2'b00;
    end else begin
      pin_in_reg <= {cmp_neg_pin_in & pin1_buf_enable, cmp_pos_pin_in & pin0_buf_enable};
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      conv_ctrl_status_b_reg <= `RST_CONV_CTRL_STATUS_B;
    end else if (wr_byte0 & sel_conv_b) begin
      conv_ctrl_status_b_reg <= pwdata[7:0] & `MASK_CONV_CTRL_STATUS_B;
    end
  end

  // result and flag bits are never stored: one is live, the other has its own logic
  always @(posedge clk) begin
    if (!rst_b) begin
      cmp_ctrl_status_reg <= `RST_CMP_CTRL_STATUS;
    end else if (wr_byte0 & sel_cmp_ctrl) begin
      cmp_ctrl_status_reg <= pwdata[7:0] & `MASK_CMP_CTRL_STATUS;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      digital_input_disable_0_reg <= `RST_DIG_INPUT_DISABLE_0;
    end else if (wr_byte0 & sel_dig_off) begin
      digital_input_disable_0_reg <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      conv_ctrl_a_reg <= `RST_CONV_CTRL_A;
    end else if (wr_byte0 & sel_conv_a) begin
      conv_ctrl_a_reg <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      conv_mux_reg <= `RST_CONV_MUX;
    end else if (wr_byte0 & sel_conv_mux) begin
      conv_mux_reg <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      cmp_irq_mask_reg <= `RST_CMP_IRQ_MASK;
    end else if (wr_byte0 & sel_irq_mask) begin
      cmp_irq_mask_reg <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always @* begin
    rdata_next = 32'h0000_0000;
    if (rd_en) begin
      case (idx)
        {2'b00, `IDX_CONV_CTRL_STATUS_B}:  rdata_next[7:0] = conv_ctrl_status_b_reg;
        {2'b00, `IDX_CMP_CTRL_STATUS}:
          rdata_next[7:0] = cmp_ctrl_status_reg |
                            ({7'b000_0000, sync2_reg} << `BIT_CMP_RESULT) |
                            ({7'b000_0000, flag_reg} << `BIT_CMP_IRQ_FLAG);
        {2'b00, `IDX_DIG_INPUT_DISABLE_0}: rdata_next[7:0] = digital_input_disable_0_reg;
        {2'b00, `IDX_CONV_CTRL_A}:         rdata_next[7:0] = conv_ctrl_a_reg;
        {2'b00, `IDX_CONV_MUX}:            rdata_next[7:0] = conv_mux_reg;
        {2'b00, `IDX_PIN_INPUT}:           rdata_next[7:0] = {6'b00_0000, pin_in_reg};
        {2'b00, `IDX_CMP_IRQ_MASK}:        rdata_next[7:0] = cmp_irq_mask_reg;
        default:                           rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // word is loaded in the setup phase and stands through the access phase
  always @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rdata_next;
    end
  end

endmodule // cmp_ctrl

// File: logic/edge_event.v
// Purpose: edge detector that turns a change of a level into a mode-selected event pulse
// Assumes: input is already synchronous to clk
// Notes:   no event while the reserved mode is selected
`timescale 1ns/100ps
`include "cmp_ctrl_regs.vh"

module edge_event (
  // clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // level and mode
  input  wire       level,
  input  wire [1:0] mode,
  // event
  output reg        event_pulse
);

  reg level_prev_reg;

  always @(posedge clk) begin
    if (!rst_b) begin
      level_prev_reg <= 1'b0;
    end else begin
      level_prev_reg <= level;
    end
  end

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // compare with previous
  always @* begin
    case (mode)
      `MODE_TOGGLE:   event_pulse = level ^ level_prev_reg;
      `MODE_FALLING:  event_pulse = ~level & level_prev_reg;
      `MODE_RISING:   event_pulse = level & ~level_prev_reg;
      default:        event_pulse = 1'b0;
    endcase
  end

endmodule // edge_event

// File: shared/cmp_ctrl_regs.vh
// Purpose: register offsets, bit positions and reset values of the comparator control block
// Assumes: APB byte addresses, one 32-bit word per register, 8 data bits in the low lanes
// Notes:   printed offsets are not all multiples of four, so they are indices (address = 4 x index)
`ifndef CMP_CTRL_REGS_VH
`define CMP_CTRL_REGS_VH

// ****************************************************************
// register indices
// ****************************************************************
`define IDX_CONV_CTRL_STATUS_B   8'h03
`define IDX_CMP_CTRL_STATUS      8'h08
`define IDX_DIG_INPUT_DISABLE_0  8'h09
`define IDX_CONV_CTRL_A          8'h0a
`define IDX_CONV_MUX             8'h0b
`define IDX_PIN_INPUT            8'h0c
`define IDX_CMP_IRQ_MASK         8'h0d

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_NEG_MUX_ENABLE       6
`define BIT_CMP_POWER_OFF        7
`define BIT_BANDGAP_SELECT       6
`define BIT_CMP_RESULT           5
`define BIT_CMP_IRQ_FLAG         4
`define BIT_CMP_IRQ_ENABLE       3
`define BIT_CAPTURE_ROUTE_EN     2
`define BIT_IRQ_MODE_HI          1
`define BIT_IRQ_MODE_LO          0
`define BIT_PIN1_INPUT_OFF       1
`define BIT_PIN0_INPUT_OFF       0
`define BIT_CONVERTER_ENABLE     7

// ****************************************************************
// reset values and masks
// ****************************************************************
`define RST_CONV_CTRL_STATUS_B   8'h00
`define RST_CMP_CTRL_STATUS      8'h00
`define RST_DIG_INPUT_DISABLE_0  8'h00
`define RST_CONV_CTRL_A          8'h00
`define RST_CONV_MUX             8'h00
`define RST_CMP_IRQ_MASK         8'h00
`define MASK_CONV_CTRL_STATUS_B  8'hd7
`define MASK_CMP_CTRL_STATUS     8'hcf

// ****************************************************************
// interrupt mode codes
// ****************************************************************
`define MODE_TOGGLE              2'b00
`define MODE_RESERVED            2'b01
`define MODE_FALLING             2'b10
`define MODE_RISING              2'b11

`endif
